// ==== hw/reset_source_pkg.sv ====
// Purpose: shared constants and types for the reset source control block
// Assumes: 100 MHz system clock, 8-bit register port
// Notes:   timing figures are plain defaults, override through top parameters
package reset_source_pkg;

    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 4;
    localparam int CAUSE_W = 4;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_PIN_SEL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_CAUSE     = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_BO_CFG    = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_FLASH_CTL = 4'h3;

    // pin reset select codes
    localparam logic [DATA_W-1:0] PIN_SEL_IO  = 8'h55;
    localparam logic [DATA_W-1:0] PIN_SEL_RES = 8'haa;
    localparam logic [DATA_W-1:0] PIN_SEL_RST = 8'h55;

    // brownout level codes
    localparam logic [DATA_W-1:0] BO_CODE_1V7  = 8'h66;
    localparam logic [DATA_W-1:0] BO_CODE_1V9  = 8'h55;
    localparam logic [DATA_W-1:0] BO_CODE_2V55 = 8'h33;
    localparam logic [DATA_W-1:0] BO_CODE_3V15 = 8'h99;
    localparam logic [DATA_W-1:0] BO_CODE_3V8  = 8'haa;
    localparam logic [DATA_W-1:0] BO_CODE_OFF  = 8'hf0;
    localparam logic [DATA_W-1:0] BO_CFG_RST   = 8'h66;

    // flash programming control magic value
    localparam logic [DATA_W-1:0] FLASH_MAGIC = 8'h55;

    // reset cause flag positions and reset value
    localparam int CAUSE_WDT_CFG = 0;
    localparam int CAUSE_BO_CFG  = 1;
    localparam int CAUSE_BO_EVT  = 2;
    localparam int CAUSE_SEL     = 3;
    localparam logic [CAUSE_W-1:0] CAUSE_RST = 4'h0;

    // timing
    localparam int CLK_PERIOD_NS       = 10;
    localparam int SOFT_RESET_DELAY_NS = 1000;
    localparam int BO_FILTER_NS        = 1000;
    localparam int SOFT_DELAY_CYC =
        (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BO_FILTER_CYC =
        (BO_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        BO_NONE,
        BO_1V7,
        BO_1V9,
        BO_2V55,
        BO_3V15,
        BO_3V8
    } bo_level_type;

    typedef struct packed {
        logic         valid;
        logic         en;
        bo_level_type level;
    } bo_decode_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } bus_req_type;

endpackage : reset_source_pkg

// ==== hw/persist_timer.sv ====
// Purpose: counts consecutive cycles of a condition, fires once at the limit
// Assumes: cond_i synchronous to clk_i
// Notes:   fires in the LIMIT-th consecutive cycle; saturates afterwards
`timescale 1ns/1ps
`default_nettype none
module persist_timer #(
    parameter int LIMIT = 100,
    parameter int W     = $clog2(LIMIT + 1)
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic cond_i,
    input  wire logic clear_i,
    output logic      fire_o
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    wire          at_max = (cnt_q == W'(LIMIT));

    // an interrupted episode restarts from zero
    assign cnt_d  = (clear_i || !cond_i) ? '0 : (at_max ? cnt_q : cnt_q + 1'b1);
    assign fire_o = cond_i && !clear_i && (cnt_q == W'(LIMIT - 1));

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : persist_timer
`default_nettype wire

// ==== hw/cause_flags.sv ====
// Purpose: sticky event flags, set by hardware, cleared by software
// Assumes: set and clear are single-cycle requests
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module cause_flags #(
    parameter int             N   = 4,
    parameter logic [N-1:0]   RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic [N-1:0] set_i,
    input  wire logic [N-1:0] clr_i,
    output logic      [N-1:0] flags_o
);

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    flags_o[i] <= RST[i];
                end else if (set_i[i]) begin
                    flags_o[i] <= 1'b1;
                end else if (clr_i[i]) begin
                    flags_o[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : cause_flags
`default_nettype wire

// ==== hw/reset_source_control.sv ====
// Purpose: reset source control: pin select guard, brownout, cause flags
// Assumes: rstn_i is the power-on reset; all inputs synchronous to clk_i
// Notes:   device_reset_o is a one-cycle request to the chip reset logic
//
// What this block does
// - pin select 0x55 gpio, 0xaa reset, else reset
// - invalid pin select resets late, sets fault flag
// - non-warm resets restore pin select to 0x55
// - reset pin function overrides other pin sharing
// - cause register upper four bits read zero
// - select fault flag bit 3, software-only clear
// - brownout event flag bit 2, software-only clear
// - brownout config fault flag bit 1 on bad code
// - brownout reset disabled in sleep and idle
// - brownout resets only after exceeding filter time
// - decode five brownout levels and disable code
// - bad brownout code resets late, restores 0x66
// - real brownout reset keeps level register unchanged
// - writing 0x55 to flash control resets device
// - watchdog config fault flag bit 0, software clear
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module reset_source_control #(
    parameter int SOFT_DELAY_CYCLES = reset_source_pkg::SOFT_DELAY_CYC,
    parameter int FILTER_CYCLES     = reset_source_pkg::BO_FILTER_CYC
) (
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    input  wire reset_source_pkg::bus_req_type bus_i,
    input  wire logic                          low_voltage_i,
    input  wire logic                          sleep_idle_i,
    input  wire logic                          wdt_cfg_reset_i,
    input  wire logic                          other_reset_i,
    input  wire logic                          pin_alt_req_i,
    output var  logic [7:0]                    rdata_o,
    output var  logic                          device_reset_o,
    output var  logic                          pin_reset_func_o,
    output var  logic                          pin_alt_en_o,
    output var  logic                          brownout_enable_o,
    output var  reset_source_pkg::bo_level_type brownout_level_o
);

    import reset_source_pkg::*;

    logic [DATA_W-1:0]  sel_q;
    logic [DATA_W-1:0]  sel_d;
    logic [DATA_W-1:0]  bo_q;
    logic [DATA_W-1:0]  bo_d;
    logic [DATA_W-1:0]  rdata_d;
    logic [CAUSE_W-1:0] cause_q;
    logic [CAUSE_W-1:0] cause_set;
    logic [CAUSE_W-1:0] cause_clr;
    logic               sel_fire;
    logic               bo_cfg_fire;
    logic               bo_fire;
    bo_decode_type      bo_dec;
    bo_decode_type      bo_dec_d;

    function automatic bo_decode_type decode_bo(input logic [DATA_W-1:0] code);
        bo_decode_type r;
        r = '{valid: 1'b1, en: 1'b1, level: BO_1V7};
        case (code)
            BO_CODE_1V7:  r.level = BO_1V7;
            BO_CODE_1V9:  r.level = BO_1V9;
            BO_CODE_2V55: r.level = BO_2V55;
            BO_CODE_3V15: r.level = BO_3V15;
            BO_CODE_3V8:  r.level = BO_3V8;
            BO_CODE_OFF: begin
                r.en    = 1'b0;
                r.level = BO_NONE;
            end
            default: begin
                r = '{valid: 1'b0, en: 1'b0, level: BO_NONE};
            end
        endcase
        return r;
    endfunction : decode_bo

    // address decode
    wire wr_sel   = bus_i.we && (bus_i.addr == OFF_PIN_SEL);
    wire wr_cause = bus_i.we && (bus_i.addr == OFF_CAUSE);
    wire wr_bo    = bus_i.we && (bus_i.addr == OFF_BO_CFG);
    wire wr_flash = bus_i.we && (bus_i.addr == OFF_FLASH_CTL);

    // pin select decode
    wire sel_is_res = (sel_q == PIN_SEL_RES);
    wire sel_bad    = (sel_q != PIN_SEL_IO) && !sel_is_res;

    // brownout decode and arming
    assign bo_dec   = decode_bo(bo_q);
    assign bo_dec_d = decode_bo(bo_d);
    wire bo_bad     = !bo_dec.valid;
    wire lv_armed   = bo_dec.en && !sleep_idle_i && low_voltage_i;

    // magic write to the flash programming control register
    wire flash_fire = wr_flash && (bus_i.wdata == FLASH_MAGIC);

    wire own_fire   = sel_fire || bo_cfg_fire || bo_fire || flash_fire;
    // watchdog warm reset is not an input here, so it never restores select
    wire restore    = own_fire || other_reset_i || wdt_cfg_reset_i;
    wire tmr_clear  = device_reset_o || other_reset_i || wdt_cfg_reset_i;

    // soft reset delay counters; a corrected value before expiry aborts
    persist_timer #(
        .LIMIT (SOFT_DELAY_CYCLES)
    ) u_sel_delay (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .cond_i  (sel_bad),
        .clear_i (tmr_clear),
        .fire_o  (sel_fire)
    );

    persist_timer #(
        .LIMIT (SOFT_DELAY_CYCLES)
    ) u_bo_cfg_delay (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .cond_i  (bo_bad),
        .clear_i (tmr_clear),
        .fire_o  (bo_cfg_fire)
    );

    // "longer than" the filter time: one cycle past the figure
    persist_timer #(
        .LIMIT (FILTER_CYCLES + 1)
    ) u_bo_filter (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .cond_i  (lv_armed),
        .clear_i (tmr_clear),
        .fire_o  (bo_fire)
    );

    // reset cause flags
    assign cause_set[CAUSE_SEL]     = sel_fire;
    assign cause_set[CAUSE_BO_EVT]  = bo_fire;
    assign cause_set[CAUSE_BO_CFG]  = bo_cfg_fire;
    assign cause_set[CAUSE_WDT_CFG] = wdt_cfg_reset_i;
    assign cause_clr = wr_cause ? ~bus_i.wdata[CAUSE_W-1:0] : '0;

    cause_flags #(
        .N   (CAUSE_W),
        .RST (CAUSE_RST)
    ) u_cause (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .set_i   (cause_set),
        .clr_i   (cause_clr),
        .flags_o (cause_q)
    );

    // register next values; a reset restore beats a software write
    assign sel_d = restore ? PIN_SEL_RST : (wr_sel ? bus_i.wdata : sel_q);
    // only the bad-code reset restores; a real brownout leaves it alone
    assign bo_d  = bo_cfg_fire ? BO_CFG_RST : (wr_bo ? bus_i.wdata : bo_q);

    // read mux, data valid the cycle after the strobe only
    wire [DATA_W-1:0] cause_rd = {{(DATA_W - CAUSE_W){1'b0}}, cause_q};
    assign rdata_d = !bus_i.re                  ? '0       :
                     (bus_i.addr == OFF_PIN_SEL) ? sel_q    :
                     (bus_i.addr == OFF_CAUSE)   ? cause_rd :
                     (bus_i.addr == OFF_BO_CFG)  ? bo_q     : '0;

    wire res_func_d = (sel_d == PIN_SEL_RES);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_q <= PIN_SEL_RST;
            bo_q  <= BO_CFG_RST;
        end else begin
            sel_q <= sel_d;
            bo_q  <= bo_d;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o           <= '0;
            device_reset_o    <= 1'b0;
            pin_reset_func_o  <= 1'b0;
            pin_alt_en_o      <= 1'b0;
            brownout_enable_o <= 1'b0;
            brownout_level_o  <= BO_NONE;
        end else begin
            rdata_o           <= rdata_d;
            device_reset_o    <= own_fire;
            pin_reset_func_o  <= res_func_d;
            pin_alt_en_o      <= pin_alt_req_i && !res_func_d;
            brownout_enable_o <= bo_dec_d.en && !sleep_idle_i;
            brownout_level_o  <= bo_dec_d.level;
        end
    end

    // helper run counters seen only by the checks below
    logic [15:0] sel_run_q;
    logic [15:0] bo_run_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_run_q <= '0;
            bo_run_q  <= '0;
        end else begin
            sel_run_q <= (tmr_clear || !sel_bad) ? '0 :
                         ((&sel_run_q) ? sel_run_q : sel_run_q + 16'h0001);
            bo_run_q  <= (tmr_clear || !lv_armed) ? '0 :
                         ((&bo_run_q) ? bo_run_q : bo_run_q + 16'h0001);
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_pin_func;
        pin_reset_func_o == (sel_q == PIN_SEL_RES);
    endproperty
    a_pin_func: assert property (p_pin_func)
        else $error("pin reset function does not follow select register");

    property p_sel_delay;
        sel_fire |-> sel_run_q == 16'(SOFT_DELAY_CYCLES - 1);
    endproperty
    a_sel_delay: assert property (p_sel_delay)
        else $error("select fault reset not after soft reset delay");

    property p_sel_fault;
        sel_fire |=> device_reset_o && cause_q[CAUSE_SEL];
    endproperty
    a_sel_fault: assert property (p_sel_fault)
        else $error("select fault reset missing reset or flag");

    property p_sel_restore;
        device_reset_o || $past(other_reset_i) || $past(wdt_cfg_reset_i)
            |-> sel_q == PIN_SEL_RST;
    endproperty
    a_sel_restore: assert property (p_sel_restore)
        else $error("pin select not restored by reset");

    property p_alt_blocked;
        pin_reset_func_o |-> !pin_alt_en_o;
    endproperty
    a_alt_blocked: assert property (p_alt_blocked)
        else $error("pin sharing enabled while reset function selected");

    property p_upper_zero;
        $past(bus_i.re) && $past(bus_i.addr) == OFF_CAUSE |-> rdata_o[7:4] == 4'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("cause register upper bits not zero");

    property p_sticky;
        cause_q[CAUSE_SEL] && !(wr_cause && !bus_i.wdata[CAUSE_SEL])
            |=> cause_q[CAUSE_SEL];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("select fault flag dropped without software clear");

    property p_bo_event;
        bo_fire |=> device_reset_o && cause_q[CAUSE_BO_EVT];
    endproperty
    a_bo_event: assert property (p_bo_event)
        else $error("brownout reset missing reset or flag");

    property p_bo_cfg;
        bo_cfg_fire |=> cause_q[CAUSE_BO_CFG] && bo_q == BO_CFG_RST && device_reset_o;
    endproperty
    a_bo_cfg: assert property (p_bo_cfg)
        else $error("bad brownout code reset incomplete");

    property p_sleep;
        sleep_idle_i |-> !bo_fire;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("brownout reset while in sleep or idle");

    property p_filter;
        bo_fire |-> bo_run_q == 16'(FILTER_CYCLES);
    endproperty
    a_filter: assert property (p_filter)
        else $error("brownout reset not after filter time");

    property p_bo_keep;
        bo_fire && !wr_bo && !bo_cfg_fire |=> bo_q == $past(bo_q);
    endproperty
    a_bo_keep: assert property (p_bo_keep)
        else $error("brownout level changed by real brownout reset");

    property p_flash;
        wr_flash && bus_i.wdata == FLASH_MAGIC |=> device_reset_o;
    endproperty
    a_flash: assert property (p_flash)
        else $error("flash magic write did not reset");

    property p_wdt_flag;
        wdt_cfg_reset_i |=> cause_q[CAUSE_WDT_CFG];
    endproperty
    a_wdt_flag: assert property (p_wdt_flag)
        else $error("watchdog config fault flag not set");

    property p_set_wins;
        bo_fire && wr_cause && !bus_i.wdata[CAUSE_BO_EVT] |=> cause_q[CAUSE_BO_EVT];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a simultaneous set");

    property p_write_one;
        !cause_q[CAUSE_SEL] && !sel_fire |=> !cause_q[CAUSE_SEL];
    endproperty
    a_write_one: assert property (p_write_one)
        else $error("select fault flag set without its event");

    property p_no_spurious;
        device_reset_o |-> $past(own_fire);
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("device reset without a source");

    property p_rdata_idle;
        !$past(bus_i.re) |-> rdata_o == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside the read answer cycle");

    property p_bo_off;
        bo_q == BO_CODE_OFF |-> !brownout_enable_o && !bo_fire;
    endproperty
    a_bo_off: assert property (p_bo_off)
        else $error("brownout active while disable code selected");

    property p_flash_other;
        wr_flash && bus_i.wdata != FLASH_MAGIC && !sel_fire && !bo_cfg_fire && !bo_fire
            |=> !device_reset_o;
    endproperty
    a_flash_other: assert property (p_flash_other)
        else $error("non-magic flash control write caused a reset");

    property p_clear_mask;
        wr_cause && cause_set == '0
            |=> cause_q == ($past(cause_q) & $past(bus_i.wdata[CAUSE_W-1:0]));
    endproperty
    a_clear_mask: assert property (p_clear_mask)
        else $error("cause write did not keep ones and clear zeros");

    c_sel_fault: cover property (sel_fire ##1 device_reset_o);
    c_bo_real:   cover property (bo_fire ##1 device_reset_o);
    c_bo_cfg:    cover property (bo_cfg_fire ##1 device_reset_o);
    c_flash:     cover property (flash_fire ##1 device_reset_o);
    c_set_clr:   cover property (wdt_cfg_reset_i && wr_cause && !bus_i.wdata[CAUSE_WDT_CFG]);

endmodule : reset_source_control
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: self-checking bench for the reset source control block
// Assumes: short soft delay and filter counts keep the run brief
// Notes:   read data checked by a queue-fed monitor; outputs sampled at negedge
`timescale 1ns/1ps
`default_nettype none
module tb;
    import reset_source_pkg::*;

    localparam int SOFT = 4;
    localparam int FILT = 3;
    localparam logic [7:0]   CODES [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0};
    localparam bo_level_type LVLS  [6] = '{BO_1V7, BO_1V9, BO_2V55, BO_3V15, BO_3V8, BO_NONE};

    logic         clk_i;
    logic         rstn_i;
    bus_req_type  bus;
    logic         low_v;
    logic         slp;
    logic         wdt_rst;
    logic         oth_rst;
    logic         alt_req;
    logic [7:0]   rdata;
    logic         dev_rst;
    logic         pin_func;
    logic         alt_en;
    logic         bo_en;
    bo_level_type bo_lvl;
    logic [7:0]   rd_q [$];
    logic         rd_pend;
    logic [7:0]   v;
    logic [3:0]   cause;
    int           err_count;
    int           checks_done;
    int           rst_cnt;
    int           rst_exp;

    reset_source_control #(
        .SOFT_DELAY_CYCLES (SOFT),
        .FILTER_CYCLES     (FILT)
    ) dut (
        .clk_i             (clk_i),
        .rstn_i            (rstn_i),
        .bus_i             (bus),
        .low_voltage_i     (low_v),
        .sleep_idle_i      (slp),
        .wdt_cfg_reset_i   (wdt_rst),
        .other_reset_i     (oth_rst),
        .pin_alt_req_i     (alt_req),
        .rdata_o           (rdata),
        .device_reset_o    (dev_rst),
        .pin_reset_func_o  (pin_func),
        .pin_alt_en_o      (alt_en),
        .brownout_enable_o (bo_en),
        .brownout_level_o  (bo_lvl)
    );

    always #5 clk_i = ~clk_i;

    task automatic end_of_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // old values seen at the edge, so no race with the design's updates
    always @(posedge clk_i) begin
        if (rd_pend === 1'b1 && rd_q.size() > 0) begin
            chk(rdata, rd_q.pop_front());
        end
        rd_pend <= bus.re;
        if (dev_rst === 1'b1) begin
            rst_cnt++;
        end
    end

    // a gap cycle between strobes keeps each strobe assigned once a step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.we    <= 1'b1;
        @(posedge clk_i);
        bus.we    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_q.push_back(e);
        bus.addr <= a;
        bus.re   <= 1'b1;
        @(posedge clk_i);
        bus.re   <= 1'b0;
    endtask : rd

    task automatic wait_rst(input int exp_n);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (dev_rst !== 1'b1 && n < 40);
        chk(n[7:0], exp_n[7:0]);
        rst_exp++;
    endtask : wait_rst

    task automatic quiet(input int n);
        repeat (n) @(negedge clk_i);
        chk(rst_cnt[7:0], rst_exp[7:0]);
    endtask : quiet

    task automatic pulse_low(input int n, input logic sleep);
        @(posedge clk_i);
        low_v <= 1'b1;
        slp   <= sleep;
        repeat (n) @(posedge clk_i);
        low_v <= 1'b0;
        slp   <= 1'b0;
    endtask : pulse_low

    initial begin
        #20000;
        err_count++;
        end_of_test();
    end

    initial begin
        clk_i = 1'b0;
        rstn_i = 1'b0;
        bus = '0;
        low_v = 1'b0;
        slp = 1'b0;
        wdt_rst = 1'b0;
        oth_rst = 1'b0;
        alt_req = 1'b0;
        rd_pend = 1'b0;
        cause = 4'h0;
        err_count = 0;
        checks_done = 0;
        rst_cnt = 0;
        rst_exp = 0;
        void'($urandom(57058));
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(OFF_PIN_SEL, 8'h55);
        rd(OFF_CAUSE, 8'h00);
        rd(OFF_BO_CFG, 8'h66);
        rd(OFF_FLASH_CTL, 8'h00);
        rd(4'h4 + 4'($urandom_range(11, 0)), 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(OFF_BO_CFG, CODES[i]);
            repeat (2) @(negedge clk_i);
            chk({5'h0, bo_lvl}, {5'h0, LVLS[i]});
            chk({7'h0, bo_en}, {7'h0, (i < 5)});
            rd(OFF_BO_CFG, CODES[i]);
        end
        wr(OFF_BO_CFG, 8'h66);
        @(posedge clk_i);
        slp <= 1'b1;
        repeat (2) @(negedge clk_i);
        chk({7'h0, bo_en}, 8'h00);
        // pin sharing: reset function must win over the other user
        @(posedge clk_i);
        slp     <= 1'b0;
        alt_req <= 1'b1;
        wr(OFF_PIN_SEL, 8'haa);
        repeat (2) @(negedge clk_i);
        chk({7'h0, pin_func}, 8'h01);
        chk({7'h0, alt_en}, 8'h00);
        wr(OFF_PIN_SEL, 8'h55);
        repeat (2) @(negedge clk_i);
        chk({7'h0, pin_func}, 8'h00);
        chk({7'h0, alt_en}, 8'h01);
        wr(OFF_PIN_SEL, 8'haa);
        @(posedge clk_i);
        oth_rst <= 1'b1;
        @(posedge clk_i);
        oth_rst <= 1'b0;
        rd(OFF_PIN_SEL, 8'h55);
        do v = 8'($urandom()); while (v == 8'h55 || v == 8'haa);
        wr(OFF_PIN_SEL, v);
        wait_rst(SOFT + 1);
        cause[3] = 1'b1;
        rd(OFF_CAUSE, {4'h0, cause});
        rd(OFF_PIN_SEL, 8'h55);
        // corrected before expiry: no reset
        wr(OFF_PIN_SEL, v);
        wr(OFF_PIN_SEL, 8'h55);
        quiet(12);
        wr(OFF_CAUSE, 8'hff);
        rd(OFF_CAUSE, {4'h0, cause});
        wr(OFF_CAUSE, 8'hf7);
        cause[3] = 1'b0;
        rd(OFF_CAUSE, {4'h0, cause});
        wr(OFF_BO_CFG, 8'h12);
        wait_rst(SOFT + 1);
        cause[1] = 1'b1;
        rd(OFF_CAUSE, {4'h0, cause});
        rd(OFF_BO_CFG, 8'h66);
        wr(OFF_CAUSE, 8'hfd);
        cause[1] = 1'b0;
        pulse_low(FILT, 1'b0);
        quiet(10);
        pulse_low(12, 1'b1);
        quiet(4);
        wr(OFF_BO_CFG, 8'hf0);
        pulse_low(12, 1'b0);
        quiet(4);
        wr(OFF_BO_CFG, 8'h33);
        @(posedge clk_i);
        low_v <= 1'b1;
        wait_rst(FILT + 2);
        @(posedge clk_i);
        low_v <= 1'b0;
        cause[2] = 1'b1;
        rd(OFF_CAUSE, {4'h0, cause});
        rd(OFF_BO_CFG, 8'h33);
        wr(OFF_CAUSE, 8'hfb);
        cause[2] = 1'b0;
        wr(OFF_FLASH_CTL, 8'h54);
        quiet(4);
        wr(OFF_FLASH_CTL, 8'h55);
        wait_rst(1);
        wr(OFF_PIN_SEL, 8'haa);
        @(posedge clk_i);
        wdt_rst <= 1'b1;
        @(posedge clk_i);
        wdt_rst <= 1'b0;
        cause[0] = 1'b1;
        rd(OFF_CAUSE, {4'h0, cause});
        rd(OFF_PIN_SEL, 8'h55);
        // clear and set in one cycle: the set must stay
        @(posedge clk_i);
        bus.addr  <= OFF_CAUSE;
        bus.wdata <= 8'h00;
        bus.we    <= 1'b1;
        wdt_rst   <= 1'b1;
        @(posedge clk_i);
        bus.we    <= 1'b0;
        wdt_rst   <= 1'b0;
        rd(OFF_CAUSE, 8'h01);
        wr(OFF_CAUSE, 8'h00);
        rd(OFF_CAUSE, 8'h00);
        quiet(4);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
